// ==== led_pattern_sequencer.v ====
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "led_pattern_consts.vh"
// What this block does
// - Ramp up to level over shared rise time
// - Log ramp default, linear by control bit
// - Ramp down to off over shared fall
// - Hold level for shared on time
// - Stay off for off time, then restart
// - Timing shared; level, mask and offset per channel
// - All channels start from common point
// - Pause between pulses in multi mode
// - Emit set pulse count, then off time
// - Pause and count shared by channels
// - Pattern repeats forever as frames
// - Per-channel mask skips one to seven frames
// - Mask N skips N frames after each played
// - Masking works with either pulse mode
// - Per-channel start offset of N frames
// - Offset combines with masking and modes
// - Frame boundaries common to all channels
module led_pattern_sequencer #(
  parameter CLK_HZ = 250000000,
  parameter TICK_CYCLES = (CLK_HZ / 1000) * (`TICK_NS / 1000000)
) (
  // Clock and reset
  input wire clock,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Channel drive levels
  output reg [7:0] ledChannel1,
  output reg [7:0] ledChannel2,
  output reg [7:0] ledChannel3,
  output reg [7:0] ledChannel4
);
  // ----------------------------------------
  // State codes
  // ----------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_RISE = 3'h1;
  localparam S_ON = 3'h2;
  localparam S_FALL = 3'h3;
  localparam S_PAUSE = 3'h4;
  localparam S_OFF = 3'h5;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [2:0] ctrl_q;
  reg [13:0] riseTime_q;
  reg [13:0] fallTime_q;
  reg [12:0] onTime_q;
  reg [13:0] offTime_q;
  reg [9:0] interPulsePause_q;
  reg [2:0] pulseCount_q;
  reg [31:0] driveLevel_q;
  reg [11:0] skipCount_q;
  reg [11:0] startOffset_q;
  reg [2:0] state_q;
  reg [13:0] phaseCnt_q;
  reg [13:0] phaseLen_q;
  reg [2:0] pulseIdx_q;
  reg [31:0] tickCnt_q;
  reg [7:0] ramp_q;
  reg [11:0] maskCnt_q;
  reg [11:0] delayCnt_q;
  reg frameEnd;
  reg [31:0] readMux;
  wire tick;
  wire wrEn;
  wire [12:0] onClamp;
  wire [13:0] offClamp;
  wire [13:0] rampClamp;
  wire [9:0] pauseClamp;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wrEn = psel & penable & pwrite;
  assign tick = (tickCnt_q == TICK_CYCLES - 1);

  // ----------------------------------------
  // Write limits
  // ----------------------------------------
  // Clipped on write, so reads show the value in use and no bad value stalls
  assign onClamp = (pwdata[12:0] < `ON_MIN_MS) ? `ON_MIN_MS :
                   (pwdata[12:0] > `ON_MAX_MS) ? `ON_MAX_MS : pwdata[12:0];
  assign offClamp = (pwdata[13:0] < `OFF_MIN_MS) ? `OFF_MIN_MS :
                    (pwdata[13:0] > `OFF_MAX_MS) ? `OFF_MAX_MS : pwdata[13:0];
  assign rampClamp = `RAMP_MAX_MS;
  assign pauseClamp = (pwdata[9:0] > `PAUSE_MAX_MS) ? `PAUSE_MAX_MS : pwdata[9:0];

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      ctrl_q <= 3'h0;
      riseTime_q <= `RST_RISE;
      fallTime_q <= `RST_FALL;
      onTime_q <= `RST_ON;
      offTime_q <= `RST_OFF;
      interPulsePause_q <= `RST_PAUSE;
      pulseCount_q <= `RST_PULSES;
      driveLevel_q <= 32'h0;
      skipCount_q <= 12'h0;
      startOffset_q <= 12'h0;
    end else if (wrEn) begin
      case (paddr)
        `ADDR_CTRL: ctrl_q <= pwdata[2:0];
        `ADDR_RISE: riseTime_q <= (pwdata[13:0] > rampClamp) ? rampClamp : pwdata[13:0];
        `ADDR_FALL: fallTime_q <= (pwdata[13:0] > rampClamp) ? rampClamp : pwdata[13:0];
        `ADDR_ON: onTime_q <= onClamp;
        `ADDR_OFF: offTime_q <= offClamp;
        `ADDR_PAUSE: interPulsePause_q <= pauseClamp;
        `ADDR_PULSES: pulseCount_q <= (pwdata[2:0] == 3'h0) ? 3'h1 : pwdata[2:0];
        `ADDR_LEVEL: driveLevel_q <= pwdata;
        `ADDR_SKIP: skipCount_q <= pwdata[11:0];
        `ADDR_OFFSET: startOffset_q <= pwdata[11:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Read-back
  // ----------------------------------------
  always @* begin
    case (paddr)
      `ADDR_CTRL: readMux = {29'h0, ctrl_q};
      `ADDR_RISE: readMux = {18'h0, riseTime_q};
      `ADDR_FALL: readMux = {18'h0, fallTime_q};
      `ADDR_ON: readMux = {19'h0, onTime_q};
      `ADDR_OFF: readMux = {18'h0, offTime_q};
      `ADDR_PAUSE: readMux = {22'h0, interPulsePause_q};
      `ADDR_PULSES: readMux = {29'h0, pulseCount_q};
      `ADDR_LEVEL: readMux = driveLevel_q;
      `ADDR_SKIP: readMux = {20'h0, skipCount_q};
      `ADDR_OFFSET: readMux = {20'h0, startOffset_q};
      `ADDR_STATUS: readMux = {13'h0, pulseIdx_q, ramp_q, 5'h0, state_q};
      default: readMux = 32'h0;
    endcase
  end

  // Captured in the setup phase so the word stands through the access phase
  always @(posedge clock) begin
    if (rst)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= readMux;
  end

  // ----------------------------------------
  // Time base: one tick per millisecond
  // ----------------------------------------
  always @(posedge clock) begin
    if (rst || !ctrl_q[`CTRL_RUN_BIT] || tick)
      tickCnt_q <= 32'h0;
    else
      tickCnt_q <= tickCnt_q + 32'h1;
  end

  // ----------------------------------------
  // Shared phase sequencer
  // ----------------------------------------
  always @* begin
    frameEnd = tick && state_q == S_OFF && phaseCnt_q + 14'h1 >= phaseLen_q;
  end

  always @(posedge clock) begin
    if (rst || !ctrl_q[`CTRL_RUN_BIT]) begin
      state_q <= S_IDLE;
      phaseCnt_q <= 14'h0;
      phaseLen_q <= 14'h0;
      pulseIdx_q <= 3'h0;
    end else if (state_q == S_IDLE) begin
      state_q <= S_RISE;
      phaseCnt_q <= 14'h0;
      phaseLen_q <= riseTime_q;
      pulseIdx_q <= 3'h0;
    end else if (tick) begin
      if (phaseCnt_q + 14'h1 < phaseLen_q) begin
        phaseCnt_q <= phaseCnt_q + 14'h1;
      end else begin
        phaseCnt_q <= 14'h0;
        case (state_q)
          S_RISE: begin
            state_q <= S_ON;
            phaseLen_q <= {1'b0, onTime_q};
          end
          S_ON: begin
            state_q <= S_FALL;
            phaseLen_q <= fallTime_q;
          end
          S_FALL: begin
            if (ctrl_q[`CTRL_MULTI_BIT] && pulseIdx_q + 3'h1 < pulseCount_q) begin
              state_q <= S_PAUSE;
              phaseLen_q <= {4'h0, interPulsePause_q};
              pulseIdx_q <= pulseIdx_q + 3'h1;
            end else begin
              state_q <= S_OFF;
              phaseLen_q <= offTime_q;
            end
          end
          S_PAUSE: begin
            state_q <= S_RISE;
            phaseLen_q <= riseTime_q;
          end
          S_OFF: begin
            state_q <= S_RISE;
            phaseLen_q <= riseTime_q;
            pulseIdx_q <= 3'h0;
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Shared ramp fraction, 0..255
  // ----------------------------------------
  wire [21:0] linUp = (phaseLen_q == 14'h0) ? 22'h0 : ({phaseCnt_q, 8'h0} / {8'h0, phaseLen_q});
  reg [7:0] lin;
  reg [7:0] curve;
  reg [15:0] sq;
  always @* begin
    lin = 8'h0;
    case (state_q)
      S_RISE: lin = linUp[7:0];
      S_ON: lin = 8'hFF;
      S_FALL: lin = 8'hFF - linUp[7:0];
      default: lin = 8'h0;
    endcase
    // Square law approximates a perceptual log curve cheaply
    sq = {8'h0, lin} * {8'h0, lin};
    // Full scale stays full, else the hold sits one or two steps below the set level
    curve = ctrl_q[`CTRL_LINEAR_BIT] ? lin : (lin == 8'hFF) ? 8'hFF : sq[15:8];
  end

  always @(posedge clock) begin
    if (rst)
      ramp_q <= 8'h0;
    else
      ramp_q <= curve;
  end

  // ----------------------------------------
  // Per-channel frame gating
  // ----------------------------------------
  reg [3:0] play;
  integer i;
  integer j;
  always @(posedge clock) begin
    if (rst || !ctrl_q[`CTRL_RUN_BIT]) begin
      maskCnt_q <= 12'h0;
      delayCnt_q <= startOffset_q;
    end else if (frameEnd) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (delayCnt_q[3*i +: 3] != 3'h0) begin
          delayCnt_q[3*i +: 3] <= delayCnt_q[3*i +: 3] - 3'h1;
        end else if (maskCnt_q[3*i +: 3] == 3'h0) begin
          maskCnt_q[3*i +: 3] <= skipCount_q[3*i +: 3];
        end else begin
          maskCnt_q[3*i +: 3] <= maskCnt_q[3*i +: 3] - 3'h1;
        end
      end
    end
  end

  always @* begin
    for (j = 0; j < 4; j = j + 1)
      play[j] = (delayCnt_q[3*j +: 3] == 3'h0) && (maskCnt_q[3*j +: 3] == 3'h0);
  end

  // ----------------------------------------
  // Output scaling
  // ----------------------------------------
  function [7:0] scale;
    input [7:0] lvl;
    input [7:0] frac;
    reg [15:0] p;
    begin
      p = lvl * frac;
      scale = p[15:8] + ((frac == 8'hFF) && (lvl != 8'h0) ? 8'h1 : 8'h0);
    end
  endfunction

  always @(posedge clock) begin
    if (rst) begin
      ledChannel1 <= 8'h0;
      ledChannel2 <= 8'h0;
      ledChannel3 <= 8'h0;
      ledChannel4 <= 8'h0;
    end else begin
      ledChannel1 <= play[0] ? scale(driveLevel_q[7:0], ramp_q) : 8'h0;
      ledChannel2 <= play[1] ? scale(driveLevel_q[15:8], ramp_q) : 8'h0;
      ledChannel3 <= play[2] ? scale(driveLevel_q[23:16], ramp_q) : 8'h0;
      ledChannel4 <= play[3] ? scale(driveLevel_q[31:24], ramp_q) : 8'h0;
    end
  end
endmodule

// ==== led_pattern_consts.vh ====
`ifndef LED_PATTERN_CONSTS_VH
`define LED_PATTERN_CONSTS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_CTRL 12'h000
`define ADDR_RISE 12'h004
`define ADDR_FALL 12'h008
`define ADDR_ON 12'h00C
`define ADDR_OFF 12'h010
`define ADDR_PAUSE 12'h014
`define ADDR_PULSES 12'h018
`define ADDR_LEVEL 12'h01C
`define ADDR_SKIP 12'h020
`define ADDR_OFFSET 12'h024
`define ADDR_STATUS 12'h028
// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_RUN_BIT 0
`define CTRL_LINEAR_BIT 1
`define CTRL_MULTI_BIT 2
// ----------------------------------------
// Timing, ms per step, step field widths
// ----------------------------------------
`define TICK_NS 1000000
`define RAMP_MAX_MS 14'h20C6
`define ON_MIN_MS 13'h0032
`define ON_MAX_MS 13'h1068
`define OFF_MIN_MS 14'h0050
`define OFF_MAX_MS 14'h20D0
`define PAUSE_MAX_MS 10'h21C
// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_RISE 14'h0200
`define RST_FALL 14'h0200
`define RST_ON 13'h01F4
`define RST_OFF 14'h03E8
`define RST_PAUSE 10'h000
`define RST_PULSES 3'h1
`endif

// ==== led_pattern_assertions.sv ====
`timescale 1ns/1ps
`include "led_pattern_consts.vh"
module led_pattern_assertions (
  // Clock and reset
  input wire clock,
  input wire rst,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  // Drive levels
  input wire [7:0] ledChannel1,
  input wire [7:0] ledChannel2,
  input wire [7:0] ledChannel3,
  input wire [7:0] ledChannel4
);
  // ----
  // Configuration shadow
  // ----
  logic [31:0] lev_q;
  logic [11:0] skip_q;
  logic [11:0] off_q;
  logic [2:0] known_q;
  logic multi_q;
  wire [7:0] lv1 = lev_q[7:0];
  // Pair checks only once every field has been written
  wire same12 = &known_q && lev_q[15:8] == lv1 && skip_q[5:3] == skip_q[2:0] && off_q[5:3] == off_q[2:0];
  wire same34 = &known_q && lev_q[31:24] == lev_q[23:16] && skip_q[11:9] == skip_q[8:6] && off_q[11:9] == off_q[8:6];
  always @(posedge clock) begin
    if (rst) begin
      known_q <= 3'h0;
      multi_q <= 1'b0;
    end else if (psel && penable && pwrite) begin
      case (paddr)
        `ADDR_CTRL: multi_q <= pwdata[`CTRL_MULTI_BIT];
        `ADDR_LEVEL: {known_q[0], lev_q} <= {1'b1, pwdata};
        `ADDR_SKIP: {known_q[1], skip_q} <= {1'b1, pwdata[11:0]};
        `ADDR_OFFSET: {known_q[2], off_q} <= {1'b1, pwdata[11:0]};
        default: ;
      endcase
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_reach1;
    ledChannel1 != lv1 ##1 ledChannel1 == lv1 && known_q[0];
  endsequence
  sequence s_dark1;
    ledChannel1 != 8'h00 ##1 ledChannel1 == 8'h00 && !multi_q;
  endsequence
  a_bus_ok: assert property (pready && !pslverr)
    else $error("bus answer wrong");
  a_unmapped_zero: assert property (psel && penable && paddr > `ADDR_STATUS |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_dark: assert property ($fell(rst) |-> {ledChannel1, ledChannel2, ledChannel3, ledChannel4} == 32'h0)
    else $error("lit after reset");
  a_level_cap: assert property (known_q[0] |-> ledChannel1 <= lv1 && ledChannel2 <= lev_q[15:8] &&
    ledChannel3 <= lev_q[23:16] && ledChannel4 <= lev_q[31:24])
    else $error("above drive level");
  a_pair_same12: assert property (same12 |-> ledChannel1 == ledChannel2)
    else $error("channels 1 2 differ");
  a_pair_same34: assert property (same34 |-> ledChannel3 == ledChannel4)
    else $error("channels 3 4 differ");
  a_hold_on: assert property (s_reach1 |=> (ledChannel1 == lv1) [*8])
    else $error("on time too short");
  a_off_dark: assert property (s_dark1 |=> (ledChannel1 == 8'h00) [*8])
    else $error("off time too short");
endmodule
bind led_pattern_sequencer led_pattern_assertions u_chk (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .prdata, .pslverr, .ledChannel1, .ledChannel2, .ledChannel3, .ledChannel4);

// ==== led_load.sv ====
`timescale 1ns/1ps
module led_load (
  // Clock and reset
  input wire clock,
  input wire rst,
  // Current source drive
  input wire [7:0] drive,
  // Observed light
  output logic [7:0] flashes,
  output logic [7:0] peak
);
  // ----
  // A flash is any rise out of darkness
  // ----
  logic [7:0] last_q;
  always @(posedge clock) begin
    if (rst) begin
      flashes <= 8'h00;
      peak <= 8'h00;
      last_q <= 8'h00;
    end else begin
      last_q <= drive;
      if (last_q == 8'h00 && drive != 8'h00) flashes <= flashes + 8'h01;
      if (drive > peak) peak <= drive;
    end
  end
endmodule

// ==== led_pattern_sequencer_tb_top.sv ====
`timescale 1ns/1ps
`include "led_pattern_consts.vh"
module led_pattern_sequencer_tb_top;
  // ----
  // Harness
  // ----
  logic clock = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire pready;
  wire pslverr;
  wire [31:0] prdata;
  wire [7:0] led [4];
  wire [7:0] flashes [4];
  wire [7:0] peak [4];
  logic [31:0] expQ [$];
  int errors = 0;
  int checksDone = 0;
  initial forever #2 clock = ~clock;
  led_pattern_sequencer #(.TICK_CYCLES(2)) u_dut (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .ledChannel1(led[0]), .ledChannel2(led[1]), .ledChannel3(led[2]), .ledChannel4(led[3]));
  for (genvar k = 0; k < 4; k++) begin : g_led
    led_load u_led (.clock, .rst, .drive(led[k]), .flashes(flashes[k]), .peak(peak[k]));
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge clock)
    if (psel && penable && !pwrite && pready) check(prdata, expQ.pop_front());
  task automatic reset_dut;
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
  endtask
  function automatic int played(int f, int d, int m);
    int c = 0;
    for (int i = d; i < f; i += m + 1) c++;
    return c;
  endfunction
  // ----
  // Scenarios
  // ----
  task automatic reg_test;
    reset_dut();
    rd(`ADDR_STATUS, 32'h0);
    rd(`ADDR_RISE, `RST_RISE);
    apb(1'b1, `ADDR_ON, 32'h0000000A);
    rd(`ADDR_ON, `ON_MIN_MS);
    apb(1'b1, `ADDR_OFF, 32'h00002328);
    rd(`ADDR_OFF, `OFF_MAX_MS);
    apb(1'b1, `ADDR_PULSES, 32'h0);
    rd(`ADDR_PULSES, 32'h1);
    rd(12'h030, 32'h0);
    $display("register test done");
  endtask
  task automatic run_test(input logic [2:0] ctrl, input int p, input int f, input bit same);
    logic [31:0] lv;
    logic [11:0] sk;
    logic [11:0] of;
    int e;
    int n;
    for (int k = 0; k < 4; k++) begin
      lv[8*k+:8] = (same && k > 0) ? lv[7:0] : 8'($urandom_range(255, 16));
      sk[3*k+:3] = (same || k == 0) ? 3'h0 : 3'($urandom_range(4, 0));
      of[3*k+:3] = (same || k == 0) ? 3'h0 : 3'($urandom_range(3, 0));
    end
    reset_dut();
    apb(1'b1, `ADDR_RISE, 32'h2);
    apb(1'b1, `ADDR_FALL, 32'h2);
    apb(1'b1, `ADDR_ON, 32'h32);
    apb(1'b1, `ADDR_OFF, 32'h50);
    apb(1'b1, `ADDR_PAUSE, 32'h2);
    apb(1'b1, `ADDR_PULSES, p);
    apb(1'b1, `ADDR_LEVEL, lv);
    apb(1'b1, `ADDR_SKIP, {20'h0, sk});
    // Offsets are latched only while stopped, so run goes last
    apb(1'b1, `ADDR_OFFSET, {20'h0, of});
    apb(1'b1, `ADDR_CTRL, {29'h0, ctrl});
    for (n = 0; n < 20000 && !(flashes[0] == f * p && led[0] == 8'h00); n++) @(posedge clock);
    check(n < 20000, 1);
    repeat (10) @(posedge clock);
    for (int k = 0; k < 4; k++) begin
      e = played(f, of[3*k+:3], sk[3*k+:3]) * p;
      check(flashes[k], e);
      if (e > 0) check(peak[k], lv[8*k+:8]);
    end
    $display("pattern test %b done", ctrl);
  endtask
  initial begin
    void'($urandom(32'hECC9));
    reg_test();
    run_test(3'b001, 1, 3, 1'b1);
    run_test(3'b011, 1, 6, 1'b0);
    run_test(3'b101, 3, 5, 1'b0);
    final_report();
  end
  initial begin
    #100000;
    errors++;
    final_report();
  end
endmodule
